// [logic/wreg_ops_regs.vh]
// Opcode and field constants for the working-register compare and test block
`ifndef WREG_OPS_REGS_VH
`define WREG_OPS_REGS_VH

// ----------------------------------------------------------------
// Opcode bytes
// ----------------------------------------------------------------
`define OPC_PREFIX        8'h74
`define OPC_AND_IMM       8'h05
`define OPC_LESS_IMM      8'h35
`define OPC_ON_TEST_IMM   8'h45
`define OPC_NE_IMM        8'h65
`define OPC_EQ_IMM        8'h75

// ----------------------------------------------------------------
// Second bytes after the prefix
// ----------------------------------------------------------------
`define SUB_LESS_WREG     8'hB8
`define SUB_NE_WREG       8'hE8
`define SUB_EQ_WREG       8'hF8
`define SUB_ON_TEST_WREG  8'hC8
`define SUB_OFF_TEST_WREG 8'hD8

// ----------------------------------------------------------------
// Operation select codes
// ----------------------------------------------------------------
`define SEL_LT_A   4'h0
`define SEL_NE_A   4'h1
`define SEL_EQ_A   4'h2
`define SEL_ON_A   4'h3
`define SEL_OFF_A  4'h4
`define SEL_ANI    4'h5
`define SEL_ORI    4'h6
`define SEL_GTI    4'h7
`define SEL_LTI    4'h8
`define SEL_NEI    4'h9
`define SEL_EQI    4'hA
`define SEL_ONI    4'hB
`define SEL_NONE   4'hF

// ----------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------
`define ADDR_PAGE_MSB 15
`define ADDR_PAGE_LSB 8
`define ADDR_OFF_MSB  7
`define ADDR_OFF_LSB  0

`endif

// [logic/wreg_compare_test_ops.v]
// Decoder and executor for working-register compare, test and immediate logic ops
`timescale 1ns/100ps
`default_nettype none
`include "wreg_ops_regs.vh"

module wreg_compare_test_ops #(
  parameter [7:0] OPC_OR_IMM = 8'h15,  // OR immediate opcode
  parameter [7:0] OPC_GT_IMM = 8'h25   // Greater-than immediate opcode
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       srst,
  input  wire       clk_en,
  // Instruction byte stream
  output reg        fetch_req_q,
  input  wire       fetch_valid,
  input  wire [7:0] fetch_byte,
  // Core registers
  input  wire [7:0] acc_in,
  input  wire [7:0] page_in,
  // Working-register memory
  output reg        mem_rd_q,
  output reg        mem_wr_q,
  output reg [15:0] mem_addr_q,
  output reg  [7:0] mem_wdata_q,
  input  wire       mem_rvalid,
  input  wire [7:0] mem_rdata,
  // Flags
  output reg        zero_flag_q,
  output reg        skip_flag_q,
  output reg        half_carry_flag_q,
  output reg        carry_flag_q,
  output reg        load_chain_flag_hi_q,
  output reg        load_chain_flag_lo_q,
  // Status
  output reg        done_q,
  output reg        bad_op_q
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] S_OP  = 3'h0;
  localparam [2:0] S_B2  = 3'h1;
  localparam [2:0] S_B3  = 3'h2;
  localparam [2:0] S_RD  = 3'h3;
  localparam [2:0] S_EXE = 3'h4;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Minuend minus subtrahend minus extra, bit 8 is the borrow
  function [8:0] sub_b;
    input [7:0] a;
    input [7:0] b;
    input       c;
    begin
      sub_b = {1'b0, a} - {1'b0, b} - {8'h00, c};
    end
  endfunction

  // Operation select from the opcode bytes
  function [3:0] dec_sel;
    input       pre;
    input [7:0] op;
    input [7:0] b2;
    begin
      dec_sel = `SEL_NONE;
      if (pre) begin
        case (b2)
          `SUB_LESS_WREG:     dec_sel = `SEL_LT_A;
          `SUB_NE_WREG:       dec_sel = `SEL_NE_A;
          `SUB_EQ_WREG:       dec_sel = `SEL_EQ_A;
          `SUB_ON_TEST_WREG:  dec_sel = `SEL_ON_A;
          `SUB_OFF_TEST_WREG: dec_sel = `SEL_OFF_A;
          default:            dec_sel = `SEL_NONE;
        endcase
      end else if (op == `OPC_AND_IMM) begin
        dec_sel = `SEL_ANI;
      end else if (op == OPC_OR_IMM) begin
        dec_sel = `SEL_ORI;
      end else if (op == OPC_GT_IMM) begin
        dec_sel = `SEL_GTI;
      end else if (op == `OPC_LESS_IMM) begin
        dec_sel = `SEL_LTI;
      end else if (op == `OPC_NE_IMM) begin
        dec_sel = `SEL_NEI;
      end else if (op == `OPC_EQ_IMM) begin
        dec_sel = `SEL_EQI;
      end else if (op == `OPC_ON_TEST_IMM) begin
        dec_sel = `SEL_ONI;
      end
    end
  endfunction

  // Three-byte first bytes of this group
  function is_long;
    input [7:0] op;
    begin
      is_long = (op == `OPC_PREFIX) || (op == `OPC_AND_IMM) ||
                (op == OPC_OR_IMM) || (op == OPC_GT_IMM) ||
                (op == `OPC_LESS_IMM) || (op == `OPC_NE_IMM) ||
                (op == `OPC_EQ_IMM) || (op == `OPC_ON_TEST_IMM);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [2:0] state_q;
  reg [7:0] op_q;
  reg [7:0] b2_q;
  reg [7:0] data_q;
  reg [7:0] rdata_q;
  reg [3:0] sel_q;

  // Decode of the last byte in flight
  wire       pre_w = (op_q == `OPC_PREFIX);
  wire [3:0] sel_w = dec_sel(pre_w, op_q, b2_q);
  wire [7:0] off_w = pre_w ? fetch_byte : b2_q;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  reg       acc_form;
  reg [7:0] opa;
  reg [7:0] opb;
  reg       gt_one;
  reg [8:0] diff;
  reg [8:0] half;
  reg [7:0] and_r;
  reg [7:0] or_r;
  reg       z_sub;
  reg       z_and;
  reg       skip_c;
  reg       is_sub;
  reg       is_wr;
  reg [7:0] wr_val;

  // Operand routing, arithmetic and skip condition
  always @* begin
    acc_form = (sel_q <= `SEL_OFF_A);
    opa      = acc_form ? acc_in : rdata_q;
    opb      = acc_form ? rdata_q : data_q;
    gt_one   = (sel_q == `SEL_GTI);
    diff     = sub_b(opa, opb, gt_one);
    half     = sub_b({4'h0, opa[3:0]}, {4'h0, opb[3:0]}, gt_one);
    and_r    = opa & opb;
    or_r     = opa | opb;
    z_sub    = (diff[7:0] == 8'h00);
    z_and    = (and_r == 8'h00);
    is_sub   = 1'b0;
    is_wr    = 1'b0;
    skip_c   = 1'b0;
    wr_val   = and_r;
    case (sel_q)
      `SEL_LT_A: begin
        is_sub = 1'b1;
        skip_c = diff[8];
      end
      `SEL_NE_A: begin
        is_sub = 1'b1;
        skip_c = ~z_sub;
      end
      `SEL_EQ_A: begin
        is_sub = 1'b1;
        skip_c = z_sub;
      end
      `SEL_ON_A:  skip_c = ~z_and;
      `SEL_OFF_A: skip_c = z_and;
      `SEL_ANI: begin
        is_wr  = 1'b1;
        wr_val = and_r;
      end
      `SEL_ORI: begin
        is_wr  = 1'b1;
        wr_val = or_r;
      end
      `SEL_GTI: begin
        is_sub = 1'b1;
        skip_c = ~diff[8];
      end
      `SEL_LTI: begin
        is_sub = 1'b1;
        skip_c = diff[8];
      end
      `SEL_NEI: begin
        is_sub = 1'b1;
        skip_c = ~z_sub;
      end
      `SEL_EQI: begin
        is_sub = 1'b1;
        skip_c = z_sub;
      end
      `SEL_ONI:  skip_c = ~z_and;
      default:   skip_c = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Fetch, memory read, execute and optional write-back
  always @(posedge clk_sys) begin
    if (srst) begin
      state_q              <= S_OP;
      op_q                 <= 8'h00;
      b2_q                 <= 8'h00;
      data_q               <= 8'h00;
      rdata_q              <= 8'h00;
      sel_q                <= `SEL_NONE;
      fetch_req_q          <= 1'b0;
      mem_rd_q             <= 1'b0;
      mem_wr_q             <= 1'b0;
      mem_addr_q           <= 16'h0000;
      mem_wdata_q          <= 8'h00;
      zero_flag_q          <= 1'b0;
      skip_flag_q          <= 1'b0;
      half_carry_flag_q    <= 1'b0;
      carry_flag_q         <= 1'b0;
      load_chain_flag_hi_q <= 1'b0;
      load_chain_flag_lo_q <= 1'b0;
      done_q               <= 1'b0;
      bad_op_q             <= 1'b0;
    end else if (clk_en) begin
      done_q   <= 1'b0;
      bad_op_q <= 1'b0;
      mem_wr_q <= 1'b0;
      case (state_q)
        S_OP: begin
          fetch_req_q <= 1'b1;
          if (fetch_req_q && fetch_valid) begin
            op_q <= fetch_byte;
            if (is_long(fetch_byte)) begin
              state_q <= S_B2;
            end else begin
              // Single-byte foreign instruction: drop or flag it
              done_q      <= 1'b1;
              bad_op_q    <= ~skip_flag_q;
              skip_flag_q <= 1'b0;
            end
          end
        end
        S_B2: begin
          if (fetch_valid) begin
            b2_q    <= fetch_byte;
            state_q <= S_B3;
          end
        end
        S_B3: begin
          if (fetch_valid) begin
            data_q <= fetch_byte;
            sel_q  <= sel_w;
            if (skip_flag_q) begin
              // Skipped instruction: fetched, not executed
              skip_flag_q <= 1'b0;
              done_q      <= 1'b1;
              state_q     <= S_OP;
            end else if (sel_w == `SEL_NONE) begin
              bad_op_q <= 1'b1;
              done_q   <= 1'b1;
              state_q  <= S_OP;
            end else begin
              mem_addr_q  <= {page_in, off_w};
              mem_rd_q    <= 1'b1;
              fetch_req_q <= 1'b0;
              state_q     <= S_RD;
            end
          end
        end
        S_RD: begin
          if (mem_rvalid) begin
            mem_rd_q <= 1'b0;
            rdata_q  <= mem_rdata;
            state_q  <= S_EXE;
          end
        end
        S_EXE: begin
          load_chain_flag_hi_q <= 1'b0;
          load_chain_flag_lo_q <= 1'b0;
          skip_flag_q          <= skip_c;
          if (is_sub) begin
            zero_flag_q       <= z_sub;
            half_carry_flag_q <= half[4];
            carry_flag_q      <= diff[8];
          end else if (is_wr) begin
            zero_flag_q <= (wr_val == 8'h00);
            mem_wr_q    <= 1'b1;
            mem_wdata_q <= wr_val;
          end else begin
            zero_flag_q <= z_and;
          end
          done_q      <= 1'b1;
          fetch_req_q <= 1'b1;
          state_q     <= S_OP;
        end
        default: begin
          state_q <= S_OP;
        end
      endcase
    end
  end

endmodule // wreg_compare_test_ops
`default_nettype wire

// [dv/wreg_ops_props.sv]
// Property checker for the working-register compare and test block
`timescale 1ns/100ps
`default_nettype none
module wreg_ops_chk (
  // Clock, reset and fetch
  input wire logic        clk_sys, srst, clk_en, fetch_req_q,
  // Memory side
  input wire logic [7:0]  page_in,
  input wire logic        mem_rd_q, mem_wr_q, mem_rvalid,
  input wire logic [15:0] mem_addr_q,
  // Flags and status
  input wire logic        zero_flag_q, carry_flag_q, half_carry_flag_q,
  input wire logic        load_chain_flag_hi_q, load_chain_flag_lo_q, done_q, bad_op_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_done_pulse; done_q && clk_en |=> !done_q; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held");
  property p_bad_done; bad_op_q |-> done_q; endproperty
  a_bad_done: assert property (p_bad_done) else $error("bad without done");
  property p_chain; !load_chain_flag_hi_q && !load_chain_flag_lo_q; endproperty
  a_chain: assert property (p_chain) else $error("chain flag set");
  property p_wr_same; mem_wr_q |-> done_q && !mem_rd_q && $stable(mem_addr_q); endproperty
  a_wr_same: assert property (p_wr_same) else $error("write misplaced");
  property p_page; $rose(mem_rd_q) |-> mem_addr_q[15:8] == $past(page_in); endproperty
  a_page: assert property (p_page) else $error("page byte wrong");
  property p_no_fetch; $rose(mem_rd_q) |-> !fetch_req_q; endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("fetch during read");
  property p_exec;
    mem_rd_q && mem_rvalid && clk_en |=> !mem_rd_q ##1 done_q;
  endproperty
  a_exec: assert property (p_exec) else $error("execute late");
  property p_flags;
    !$past(srst) && ($changed(carry_flag_q) || $changed(half_carry_flag_q)
      || $changed(zero_flag_q)) |-> done_q;
  endproperty
  a_flags: assert property (p_flags) else $error("flags moved early");
endmodule // wreg_ops_chk

bind wreg_compare_test_ops wreg_ops_chk chk_u (.clk_sys, .srst, .clk_en, .fetch_req_q,
  .page_in, .mem_rd_q, .mem_wr_q, .mem_rvalid, .mem_addr_q, .zero_flag_q, .carry_flag_q,
  .half_carry_flag_q, .load_chain_flag_hi_q, .load_chain_flag_lo_q, .done_q, .bad_op_q);
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the working-register compare and test block
`timescale 1ns/100ps
`default_nettype none
`include "wreg_ops_regs.vh"
module tb;
  localparam logic [7:0] OR_OP = 8'h15;  // Chosen opcode
  localparam logic [7:0] GT_OP = 8'h25;  // Chosen opcode
  logic clk_sys = 0, srst = 1, clk_en = 1, fetch_valid = 0, mem_rvalid = 0;
  logic [7:0] fetch_byte = 8'h00, acc_in = 8'h00, page_in = 8'h00, mem_rdata = 8'h00;
  logic [7:0] mem_val = 8'h00, mem_wdata_q;
  logic [15:0] mem_addr_q, rd_addr;
  logic fetch_req_q, mem_rd_q, mem_wr_q, zero_flag_q, skip_flag_q, half_carry_flag_q;
  logic carry_flag_q, load_chain_flag_hi_q, load_chain_flag_lo_q, done_q, bad_op_q;
  logic ez = 0, es = 0, eh = 0, ec = 0, rd_seen = 0;
  int errors = 0, n_tests = 0;

  wreg_compare_test_ops #(.OPC_OR_IMM(OR_OP), .OPC_GT_IMM(GT_OP)) dut_u (.clk_sys, .srst,
    .clk_en, .fetch_req_q, .fetch_valid, .fetch_byte, .acc_in, .page_in, .mem_rd_q,
    .mem_wr_q, .mem_addr_q, .mem_wdata_q, .mem_rvalid, .mem_rdata, .zero_flag_q,
    .skip_flag_q, .half_carry_flag_q, .carry_flag_q, .load_chain_flag_hi_q,
    .load_chain_flag_lo_q, .done_q, .bad_op_q);

  // Clock
  always #2.5 clk_sys = ~clk_sys;
  // Memory answers a read one cycle later, junk outside it
  always @(negedge clk_sys) begin
    mem_rvalid <= mem_rd_q && !mem_rvalid;
    mem_rdata <= mem_rd_q ? mem_val : ~mem_rdata;
  end
  // Record the address of each completed read
  always @(posedge clk_sys) begin
    if (mem_rd_q && mem_rvalid) begin
      rd_seen <= 1;
      rd_addr <= mem_addr_q;
    end
  end

  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Feed n bytes of one instruction, then wait for its end
  task automatic feed(input logic [7:0] b1, b2, b3, input int n);
    int k;
    rd_seen = 0;
    for (k = 0; k < 20 && fetch_req_q !== 1; k++) @(negedge clk_sys);
    chk(fetch_req_q, 1'b1);
    fetch_valid = 1;
    fetch_byte = b1;
    @(negedge clk_sys);
    if (n > 1) begin
      fetch_byte = b2;
      @(negedge clk_sys);
      fetch_byte = b3;
      @(negedge clk_sys);
    end
    fetch_valid = 0;
    for (k = 0; k < 20 && done_q !== 1; k++) @(negedge clk_sys);
  endtask

  // One three-byte instruction, predicted and judged
  task automatic run(input logic [7:0] b1, b2, b3, mv, acc);
    logic [8:0] d;
    logic [7:0] x, y, r, sel, pg;
    logic h, g, pre, skd, wr;
    skd = es;
    pre = b1 == `OPC_PREFIX;
    sel = pre ? b2 : b1;
    g = !pre && b1 == GT_OP;
    x = pre ? acc : mv;
    y = pre ? mv : b3;
    d = {1'b0, x} - y - g;
    h = {1'b0, x[3:0]} < y[3:0] + g;
    r = x & y;
    wr = !skd && (sel == `OPC_AND_IMM || sel == OR_OP);
    es = 0;
    if (!skd) begin
      case (sel)
        `SUB_ON_TEST_WREG, `OPC_ON_TEST_IMM: es = r != 0;
        `SUB_OFF_TEST_WREG: es = r == 0;
        `OPC_AND_IMM: es = 0;
        OR_OP: r = x | y;
        default: begin
          r = d[7:0];
          eh = h;
          ec = d[8];
          if (sel inside {`SUB_LESS_WREG, `OPC_LESS_IMM}) es = d[8];
          else if (sel == GT_OP) es = !d[8];
          else es = (sel inside {`SUB_EQ_WREG, `OPC_EQ_IMM}) == (r == 0);
        end
      endcase
      ez = r == 0;
    end
    pg = b1 ^ b2 ^ 8'h3C;
    page_in = pg;
    acc_in = acc;
    mem_val = mv;
    feed(b1, b2, b3, 3);
    chk({done_q, bad_op_q}, 2'b10);
    chk({zero_flag_q, skip_flag_q, half_carry_flag_q, carry_flag_q}, {ez, es, eh, ec});
    chk({load_chain_flag_hi_q, load_chain_flag_lo_q, mem_wr_q}, {2'b00, wr});
    chk(rd_seen, !skd);
    if (!skd) chk(rd_addr, {pg, pre ? b3 : b2});
    if (wr) chk(mem_wdata_q, r);
    @(negedge clk_sys);
  endtask

  task automatic pr(input logic [7:0] b2, b3, mv, acc);
    run(`OPC_PREFIX, b2, b3, mv, acc);
  endtask

  // Accumulator against working register, skips chained
  task automatic t_prefix;
    pr(`SUB_LESS_WREG, 8'h01, 8'h10, 8'h0F);
    pr(`SUB_NE_WREG, 8'h02, 8'h00, 8'h00);
    pr(`SUB_LESS_WREG, 8'h03, 8'h01, 8'h10);
    pr(`SUB_EQ_WREG, 8'h04, 8'h80, 8'h80);
    pr(`SUB_ON_TEST_WREG, 8'h05, 8'hFF, 8'hFF);
    pr(`SUB_ON_TEST_WREG, 8'h06, 8'hF0, 8'h0F);
    pr(`SUB_ON_TEST_WREG, 8'h07, 8'h01, 8'h03);
    pr(`SUB_OFF_TEST_WREG, 8'h08, 8'h00, 8'h00);
    pr(`SUB_OFF_TEST_WREG, 8'h09, 8'hF0, 8'h0F);
    pr(`SUB_NE_WREG, 8'h0A, 8'h00, 8'h00);
    pr(`SUB_NE_WREG, 8'h0B, 8'h01, 8'h10);
    pr(`SUB_EQ_WREG, 8'h0C, 8'h00, 8'h00);
    pr(`SUB_EQ_WREG, 8'h0D, 8'h01, 8'h02);
    pr(`SUB_NE_WREG, 8'h0E, 8'h33, 8'h33);
    pr(`SUB_OFF_TEST_WREG, 8'h0F, 8'h01, 8'h01);
  endtask

  // Working register against immediate, boundary values
  task automatic t_imm;
    run(GT_OP, 8'h20, 8'h7F, 8'h80, 8'h00);
    run(`OPC_LESS_IMM, 8'h21, 8'h00, 8'h00, 8'h00);
    run(GT_OP, 8'h21, 8'h80, 8'h80, 8'h00);
    run(`OPC_LESS_IMM, 8'h22, 8'h81, 8'h80, 8'h00);
    run(`OPC_NE_IMM, 8'h23, 8'h00, 8'h00, 8'h00);
    run(`OPC_NE_IMM, 8'h23, 8'h00, 8'hFF, 8'h00);
    run(`OPC_EQ_IMM, 8'h24, 8'h55, 8'h55, 8'h00);
    run(`OPC_EQ_IMM, 8'h24, 8'h55, 8'h55, 8'h00);
    run(`OPC_ON_TEST_IMM, 8'h25, 8'h01, 8'h01, 8'h00);
    run(`OPC_ON_TEST_IMM, 8'h26, 8'h01, 8'hFE, 8'h00);
    run(`OPC_ON_TEST_IMM, 8'h27, 8'h80, 8'hFF, 8'h00);
    run(`OPC_LESS_IMM, 8'h28, 8'h10, 8'h10, 8'h00);
    run(`OPC_LESS_IMM, 8'h28, 8'h10, 8'h10, 8'h00);
    run(`OPC_EQ_IMM, 8'h29, 8'h01, 8'h02, 8'h00);
    run(`OPC_NE_IMM, 8'hFF, 8'h33, 8'h33, 8'h00);
  endtask

  // Immediate write-backs, one of them skipped
  task automatic t_logic;
    run(`OPC_AND_IMM, 8'h40, 8'h3C, 8'hF0, 8'h00);
    run(OR_OP, 8'hFF, 8'h00, 8'h00, 8'h00);
    pr(`SUB_EQ_WREG, 8'h41, 8'h5A, 8'h5A);
    run(`OPC_AND_IMM, 8'h42, 8'hFF, 8'hFF, 8'h00);
    run(OR_OP, 8'h01, 8'hA5, 8'h0F, 8'h00);
  endtask

  // Clock enable low holds the write-back cycle in place
  task automatic t_freeze;
    page_in = 8'h77;
    mem_val = 8'h0F;
    feed(OR_OP, 8'h50, 8'hF0, 3);
    clk_en = 0;
    repeat (3) @(negedge clk_sys);
    chk({done_q, mem_wr_q, zero_flag_q, skip_flag_q}, 4'b1100);
    chk(mem_wdata_q, 8'hFF);
    chk(mem_addr_q, 16'h7750);
    clk_en = 1;
    @(negedge clk_sys);
    chk({done_q, mem_wr_q}, 2'b00);
    ez = 0;
    es = 0;
  endtask

  // Opcodes outside the group: plain, prefixed, and while a skip is pending
  task automatic t_bad;
    feed(8'h55, 8'h00, 8'h00, 1);
    chk({done_q, bad_op_q, mem_rd_q, rd_seen}, 4'b1100);
    @(negedge clk_sys);
    feed(`OPC_PREFIX, 8'h00, 8'h12, 3);
    chk({done_q, bad_op_q, rd_seen}, 3'b110);
    chk({zero_flag_q, skip_flag_q, half_carry_flag_q, carry_flag_q}, {ez, es, eh, ec});
    @(negedge clk_sys);
    run(`OPC_EQ_IMM, 8'h31, 8'h44, 8'h44, 8'h00);
    feed(8'h55, 8'h00, 8'h00, 1);
    chk({done_q, bad_op_q, skip_flag_q, rd_seen}, 4'b1000);
    es = 0;
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    srst = 0;
    @(negedge clk_sys);
    t_prefix;
    t_imm;
    t_logic;
    t_freeze;
    t_bad;
    conclude;
  end
  // Watchdog
  initial begin
    #20000;
    errors++;
    conclude;
  end
endmodule // tb
`default_nettype wire
